//--- core/ssc_pkg.sv
package ssc_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_PB_DATA = 6'h01;
    localparam logic [5:0] IDX_PB_DIR = 6'h05;
    localparam logic [5:0] IDX_PB_PD = 6'h11;
    localparam logic [5:0] IDX_ANA_CTRL = 6'h1D;
    localparam logic [5:0] IDX_ASTAT = 6'h1E;
    localparam logic [5:0] IDX_OPTION = 6'h20;

    // reset values
    localparam logic [7:0] PB_DATA_RST = 8'h00;
    localparam logic [7:0] PB_DIR_RST = 8'h00;
    localparam logic [7:0] PB_PD_RST = 8'h00;
    localparam logic [7:0] ANA_CTRL_RST = 8'h00;
    localparam logic [7:0] OPTION_RST = 8'h00;

    // field positions
    localparam int OPT_PD_INHIBIT_BIT = 0;
    localparam int ANA_CTRL_CHARGE_BIT = 7;

    typedef struct packed {
        logic charge_control_bit;
        logic conv_mode_sel_high;
        logic conv_mode_sel_low;
        logic current_enable_bit;
        logic [3:0] rsvd;
    } ssc_ana_ctrl_type;

    typedef struct packed {
        logic [4:0] rsvd;
        logic comparator2_flag_reset;
        logic comparator2_output_status;
        logic comparator2_flag;
    } ssc_astat_type;

    typedef enum logic [1:0] {
        MODE_MANUAL = 2'b00,
        MODE_ONE = 2'b01,
        MODE_CAPTURE = 2'b10,
        MODE_AUTO = 2'b11
    } ssc_mode_type;

    function automatic logic [ADDR_W-1:0] reg_addr(input logic [5:0] idx);
        return {idx, 2'b00};
    endfunction

endpackage

//--- core/ssc_sync2.sv
`timescale 1ns/1ps
module ssc_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // async in, synced out
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    logic [W-1:0] meta;

    // meta is read only by the second stage
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            meta <= '0;
            o_sync <= '0;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end

endmodule

//--- core/ssc_top.sv
`timescale 1ns/1ps
module ssc_top import ssc_pkg::*; #(
    parameter int PB_PINS = 4
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [DATA_W-1:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic o_pready,
    output logic [DATA_W-1:0] o_prdata,
    output logic o_pslverr,
    // timer flags, same clock
    input wire logic i_capture_event_flag,
    input wire logic i_compare_event_flag,
    // analog comparator 2, asynchronous
    input wire logic i_comparator2_raw,
    output logic o_comparator2_flag,
    // ramp pin current control
    output logic o_ramp_source,
    output logic o_ramp_sink,
    // shared port b pins
    input wire logic [PB_PINS-1:0] i_pb_pin,
    output logic [PB_PINS-1:0] o_pb_out,
    output logic [PB_PINS-1:0] o_pb_oe,
    output logic [PB_PINS-1:0] o_pb_pulldown_en
);

    logic [7:0] port_b_pin_data;
    logic [7:0] port_b_direction;
    logic [7:0] port_b_pulldown_control;
    logic [7:0] option_register;
    ssc_ana_ctrl_type analog_ctrl_reg;
    ssc_ana_ctrl_type next_ana_ctrl;
    logic comparator2_flag;
    logic [PB_PINS-1:0] pin_level;
    logic cmp_two_level;
    logic cmp_two_level_d;
    logic cap_d;
    logic cmp_d;
    logic cap_rise;
    logic cmp_rise;
    logic cmp_two_rise;
    logic setup;
    logic wr_en;
    logic [7:0] wbyte;
    logic hit_data;
    logic hit_dir;
    logic hit_pd;
    logic hit_ana_ctrl;
    logic hit_astat;
    logic hit_opt;
    logic mapped;
    logic [7:0] rd_byte;
    logic [7:0] pb_read;
    logic pd_inhibit;
    ssc_mode_type mode;
    ssc_astat_type astat;
    ssc_astat_type wr_stat;

    // pin and comparator inputs cross in through two flops
    ssc_sync2 #(
        .W(PB_PINS + 1)
    ) u_ssc_sync2 (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_async({i_comparator2_raw, i_pb_pin}),
        .o_sync({cmp_two_level, pin_level})
    );

    // apb decode
    assign setup = i_psel & ~i_penable;
    assign wr_en = i_psel & i_penable & o_pready & i_pwrite & i_pstrb[0];
    assign wbyte = i_pwdata[7:0];

    always_comb begin
        hit_data = 1'b0;
        hit_dir = 1'b0;
        hit_pd = 1'b0;
        hit_ana_ctrl = 1'b0;
        hit_astat = 1'b0;
        hit_opt = 1'b0;
        if (i_paddr == reg_addr(IDX_PB_DATA)) begin
            hit_data = 1'b1;
        end else if (i_paddr == reg_addr(IDX_PB_DIR)) begin
            hit_dir = 1'b1;
        end else if (i_paddr == reg_addr(IDX_PB_PD)) begin
            hit_pd = 1'b1;
        end else if (i_paddr == reg_addr(IDX_ANA_CTRL)) begin
            hit_ana_ctrl = 1'b1;
        end else if (i_paddr == reg_addr(IDX_ASTAT)) begin
            hit_astat = 1'b1;
        end else if (i_paddr == reg_addr(IDX_OPTION)) begin
            hit_opt = 1'b1;
        end
    end

    assign mapped = hit_data | hit_dir | hit_pd | hit_ana_ctrl | hit_astat
        | hit_opt;

    // port read: latch on outputs, synced pin on inputs
    always_comb begin
        pb_read = port_b_pin_data;
        for (int i = 0; i < PB_PINS; i++) begin
            if (!port_b_direction[i]) begin
                pb_read[i] = pin_level[i];
            end
        end
    end

    always_comb begin
        astat = '0;
        astat.comparator2_flag = comparator2_flag;
        astat.comparator2_output_status = cmp_two_level;
    end

    always_comb begin
        rd_byte = 8'h00;
        if (hit_data) begin
            rd_byte = pb_read;
        end else if (hit_dir) begin
            rd_byte = port_b_direction;
        end else if (hit_pd) begin
            rd_byte = port_b_pulldown_control;
        end else if (hit_ana_ctrl) begin
            rd_byte = analog_ctrl_reg;
        end else if (hit_astat) begin
            rd_byte = astat;
        end else if (hit_opt) begin
            rd_byte = option_register;
        end
    end

    // no wait state: answer on the first access cycle
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= setup;
            if (setup) begin
                o_prdata <= {24'h00_0000, i_pwrite ? 8'h00 : rd_byte};
                o_pslverr <= ~mapped;
            end
        end
    end

    // port registers
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            port_b_pin_data <= PB_DATA_RST;
            port_b_direction <= PB_DIR_RST;
            port_b_pulldown_control <= PB_PD_RST;
            option_register <= OPTION_RST;
        end else begin
            if (wr_en && hit_data) begin
                port_b_pin_data <= wbyte;
            end
            if (wr_en && hit_dir) begin
                port_b_direction <= wbyte;
            end
            if (wr_en && hit_pd) begin
                port_b_pulldown_control <= wbyte;
            end
            if (wr_en && hit_opt) begin
                option_register <= wbyte;
            end
        end
    end

    assign pd_inhibit = option_register[OPT_PD_INHIBIT_BIT];

    // pins follow the registers one cycle later
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pb_out <= '0;
            o_pb_oe <= '0;
            o_pb_pulldown_en <= '0;
        end else begin
            o_pb_out <= port_b_pin_data[PB_PINS-1:0];
            o_pb_oe <= port_b_direction[PB_PINS-1:0];
            o_pb_pulldown_en <= port_b_pulldown_control[PB_PINS-1:0]
                & ~port_b_direction[PB_PINS-1:0]
                & ~{PB_PINS{pd_inhibit}};
        end
    end

    // timer flag rising edges
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cap_d <= 1'b0;
            cmp_d <= 1'b0;
        end else begin
            cap_d <= i_capture_event_flag;
            cmp_d <= i_compare_event_flag;
        end
    end

    assign cap_rise = i_capture_event_flag & ~cap_d;
    assign cmp_rise = i_compare_event_flag & ~cmp_d;
    assign mode = ssc_mode_type'({analog_ctrl_reg.conv_mode_sel_high,
        analog_ctrl_reg.conv_mode_sel_low});

    // software write wins over an automatic change in the same cycle
    always_comb begin
        next_ana_ctrl = analog_ctrl_reg;
        if (analog_ctrl_reg.current_enable_bit) begin
            case (mode)
                MODE_CAPTURE: begin
                    if (analog_ctrl_reg.charge_control_bit && cap_rise) begin
                        next_ana_ctrl.charge_control_bit = 1'b0;
                    end
                end
                MODE_AUTO: begin
                    if (analog_ctrl_reg.charge_control_bit) begin
                        if (cap_rise) begin
                            next_ana_ctrl.charge_control_bit = 1'b0;
                        end
                    end else if (cmp_rise) begin
                        next_ana_ctrl.charge_control_bit = 1'b1;
                    end
                end
                default: begin
                    next_ana_ctrl.charge_control_bit =
                        analog_ctrl_reg.charge_control_bit;
                end
            endcase
        end
        if (wr_en && hit_ana_ctrl) begin
            next_ana_ctrl = wbyte;
            next_ana_ctrl.rsvd = 4'h0;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            analog_ctrl_reg <= ANA_CTRL_RST;
        end else begin
            analog_ctrl_reg <= next_ana_ctrl;
        end
    end

    // ramp current drive
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ramp_source <= 1'b0;
            o_ramp_sink <= 1'b0;
        end else begin
            o_ramp_source <= analog_ctrl_reg.current_enable_bit
                & analog_ctrl_reg.charge_control_bit;
            o_ramp_sink <= analog_ctrl_reg.current_enable_bit
                & ~analog_ctrl_reg.charge_control_bit;
        end
    end

    // comparator 2 flag: trip sets, write of 1 clears, set wins
    assign cmp_two_rise = cmp_two_level & ~cmp_two_level_d;
    assign wr_stat = wbyte;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cmp_two_level_d <= 1'b0;
            comparator2_flag <= 1'b0;
        end else begin
            cmp_two_level_d <= cmp_two_level;
            if (cmp_two_rise) begin
                comparator2_flag <= 1'b1;
            end else if (wr_en && hit_astat
                && wr_stat.comparator2_flag_reset) begin
                comparator2_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_comparator2_flag <= 1'b0;
        end else begin
            o_comparator2_flag <= comparator2_flag;
        end
    end

    AST_SOURCE_WHEN_CHARGE: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        (analog_ctrl_reg.current_enable_bit
        && analog_ctrl_reg.charge_control_bit)
        |=> (o_ramp_source && !o_ramp_sink))
        else $error("ramp not sourcing with charge and enable set");

    AST_SINK_WHEN_CLR: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        (analog_ctrl_reg.current_enable_bit
        && !analog_ctrl_reg.charge_control_bit)
        |=> (o_ramp_sink && !o_ramp_source))
        else $error("ramp not sinking with charge clear");

    AST_NO_CURRENT: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        !analog_ctrl_reg.current_enable_bit
        |=> !(o_ramp_source || o_ramp_sink))
        else $error("ramp current with enable clear");

    AST_CAPTURE_CLEARS: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        (analog_ctrl_reg.current_enable_bit
        && analog_ctrl_reg.conv_mode_sel_high
        && analog_ctrl_reg.charge_control_bit && cap_rise
        && !(wr_en && hit_ana_ctrl))
        |=> !analog_ctrl_reg.charge_control_bit ##1 !o_ramp_source)
        else $error("capture flag did not end charging");

    AST_COMPARE_SETS: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        (analog_ctrl_reg.current_enable_bit && mode == MODE_AUTO
        && !analog_ctrl_reg.charge_control_bit && cmp_rise
        && !(wr_en && hit_ana_ctrl))
        |=> analog_ctrl_reg.charge_control_bit ##1 o_ramp_source)
        else $error("compare flag did not start charging");

    AST_MANUAL_HOLDS: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        (mode == MODE_MANUAL && !(wr_en && hit_ana_ctrl))
        |=> $stable(analog_ctrl_reg.charge_control_bit))
        else $error("charge bit changed in manual mode");

    AST_PULLDOWN_OFF: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        1'b1 |=> ((o_pb_pulldown_en
        & ($past(port_b_direction[PB_PINS-1:0])
        | {PB_PINS{$past(pd_inhibit)}})) == '0))
        else $error("pulldown on for output or inhibited pin");

    AST_WRITE_LATCH: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        (wr_en && hit_data)
        |=> port_b_pin_data == $past(wbyte)
        ##1 o_pb_out == $past(wbyte[PB_PINS-1:0], 2))
        else $error("port data write lost");

    AST_CHARGE_READBACK: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        (setup && !i_pwrite && hit_ana_ctrl)
        |=> (o_pready
        && o_prdata[ANA_CTRL_CHARGE_BIT]
        == $past(analog_ctrl_reg.charge_control_bit)))
        else $error("charge bit readback wrong");

    AST_FLAG_ON_TRIP: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        cmp_two_rise |=> comparator2_flag ##1 o_comparator2_flag)
        else $error("comparator 2 trip did not set flag");

endmodule

//--- verif/ssc_ramp_model.sv
`timescale 1ns/1ps
module ssc_ramp_model (
    // clock
    input wire logic i_sys_clk,
    // ramp current and port pins
    input wire logic i_source,
    input wire logic i_sink,
    input wire logic [3:0] i_out,
    input wire logic [3:0] i_oe,
    input wire logic [3:0] i_pd_en,
    // analog sources
    input wire logic [7:0] i_vx,
    input wire logic [3:1] i_ext,
    output logic o_cmp_raw,
    output logic [3:0] o_pin
);
    int cap = 0;
    // slow charge, fast discharge, like a real ramp capacitor
    always @(posedge i_sys_clk) begin
        if (i_source && cap < 255) begin
            cap <= cap + 1;
        end else if (i_sink) begin
            cap <= (cap > 4) ? cap - 4 : 0;
        end
    end
    // released pins fall to the pulldown level or follow the source
    always_comb begin
        o_cmp_raw = (cap >= i_vx);
        o_pin[0] = i_oe[0] ? i_out[0] : (cap >= 128);
        for (int i = 1; i < 4; i++) begin
            o_pin[i] = i_oe[i] ? i_out[i] : (!i_pd_en[i] && i_ext[i]);
        end
    end
endmodule

//--- verif/ssc_top_tb.sv
`timescale 1ns/1ps
module ssc_top_tb;
    import ssc_pkg::*;
    localparam logic [7:0] A_DATA = {IDX_PB_DATA, 2'b00};
    localparam logic [7:0] A_DIR = {IDX_PB_DIR, 2'b00};
    localparam logic [7:0] A_PD = {IDX_PB_PD, 2'b00};
    localparam logic [7:0] A_CTRL = {IDX_ANA_CTRL, 2'b00};
    localparam logic [7:0] A_STAT = {IDX_ASTAT, 2'b00};
    localparam logic [7:0] A_OPT = {IDX_OPTION, 2'b00};
    logic i_sys_clk = 0;
    logic i_rst = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic cap_f = 0;
    logic cmp_f = 0;
    logic [7:0] vx = 8'h14;
    logic [3:1] ext = 3'h0;
    logic pready, pslverr, cmp_flag, src, snk, raw;
    logic [31:0] prdata, d, r;
    logic [3:0] pin, pout, poe, ppd, pden, pinv, e4;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    int seed = 41539;

    always #4 i_sys_clk = ~i_sys_clk;

    ssc_top u_ssc_top (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
        .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
        .i_capture_event_flag(cap_f), .i_compare_event_flag(cmp_f),
        .i_comparator2_raw(raw), .o_comparator2_flag(cmp_flag),
        .o_ramp_source(src), .o_ramp_sink(snk),
        .i_pb_pin(pin), .o_pb_out(pout), .o_pb_oe(poe),
        .o_pb_pulldown_en(ppd)
    );

    ssc_ramp_model u_ssc_ramp_model (
        .i_sys_clk(i_sys_clk), .i_source(src), .i_sink(snk),
        .i_out(pout), .i_oe(poe), .i_pd_en(ppd), .i_vx(vx),
        .i_ext(ext), .o_cmp_raw(raw), .o_pin(pin)
    );

    task chk(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task close_out;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // one edge of idle before each setup keeps psel single-driven
    task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge i_sys_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge i_sys_clk);
        penable <= 1;
        @(posedge i_sys_clk);
        while (pready !== 1'b1) @(posedge i_sys_clk);
        psel <= 0;
        penable <= 0;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] v);
        apb(1'b1, a, {24'h0, v});
    endtask

    task rd(input logic [7:0] a, input logic [32:0] x);
        exp_q.push_back(x);
        apb(1'b0, a, 32'h0);
    endtask

    task pulse(input logic which);
        @(posedge i_sys_clk);
        if (which) cmp_f <= 1;
        else cap_f <= 1;
        @(posedge i_sys_clk);
        cap_f <= 0;
        cmp_f <= 0;
    endtask

    task settle(input int n);
        repeat (n) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
    endtask

    // read results are matched against the oldest note
    always @(posedge i_sys_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = exp_q.pop_front();
            chk({pslverr, prdata}, e);
        end
    end

    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end

    initial begin
        repeat (6) @(posedge i_sys_clk);
        i_rst <= 0;
        @(negedge i_sys_clk);
        chk({poe, pout, ppd, src, snk, cmp_flag}, 33'h0);
        rd(A_CTRL, 33'h0);
        rd(A_DIR, 33'h0);
        rd(A_PD, 33'h0);
        rd(A_OPT, 33'h0);
        rd(A_DATA, 33'h0);
        rd(8'h0C, {1'b1, 32'h0});
        @(posedge i_sys_clk);
        pstrb <= 4'h0;
        wr(A_OPT, 8'h01);
        @(posedge i_sys_clk);
        pstrb <= 4'hF;
        rd(A_OPT, 33'h0);
        for (int k = 0; k < 6; k++) begin
            d = $random(seed);
            r = $random(seed);
            @(posedge i_sys_clk);
            ext <= r[19:17];
            wr(A_DATA, d[7:0]);
            wr(A_DIR, r[7:0]);
            wr(A_PD, r[15:8]);
            wr(A_OPT, {7'h00, r[16]});
            settle(4);
            pden = r[11:8] & ~r[3:0] & {4{~r[16]}};
            pinv = {r[19:17] & ~pden[3:1], 1'b0};
            e4 = (r[3:0] & d[3:0]) | (~r[3:0] & pinv);
            rd(A_DATA, {25'h0, d[7:4], e4});
            chk(ppd, pden);
            chk(poe, r[3:0]);
            chk(pout, d[3:0]);
        end
        wr(A_DIR, 8'h00);
        wr(A_OPT, 8'h00);
        for (int k = 0; k < 8; k++) begin
            wr(A_CTRL, {k[2:0], 5'h00});
            pulse(1'b0);
            pulse(1'b1);
            settle(2);
            chk({src, snk}, 2'h0);
            rd(A_CTRL, {25'h0, k[2:0], 5'h00});
        end
        wr(A_CTRL, 8'h10);
        settle(3);
        chk({src, snk}, 2'h1);
        settle(4);
        wr(A_CTRL, 8'h90);
        pulse(1'b0);
        settle(2);
        chk({src, snk}, 2'h2);
        rd(A_CTRL, 33'h90);
        settle(40);
        chk(cmp_flag, 1'b1);
        rd(A_STAT, 33'h03);
        wr(A_CTRL, 8'h10);
        settle(30);
        wr(A_STAT, 8'h04);
        rd(A_STAT, 33'h00);
        wr(A_CTRL, 8'hD0);
        pulse(1'b0);
        rd(A_CTRL, 33'h50);
        // compare event alone must not start charging outside mode 3
        pulse(1'b1);
        rd(A_CTRL, 33'h50);
        settle(2);
        chk({src, snk}, 2'h1);
        // mode 1 keeps manual behaviour: capture leaves charge set
        wr(A_CTRL, 8'hB0);
        pulse(1'b0);
        rd(A_CTRL, 33'hB0);
        wr(A_CTRL, 8'h70);
        pulse(1'b1);
        rd(A_CTRL, 33'hF0);
        pulse(1'b0);
        rd(A_CTRL, 33'h70);
        @(posedge i_sys_clk);
        i_rst <= 1;
        @(posedge i_sys_clk);
        i_rst <= 0;
        rd(A_CTRL, 33'h0);
        settle(2);
        chk({src, snk}, 2'h0);
        chk(exp_q.size(), 33'h0);
        close_out();
    end
endmodule
